// ---- rtl/lps_pkg.sv ----
// Shared constants and types for the indicator control and page select block
// Assumes a 200 MHz clock and an APB register window with one word per register
package lps_pkg;
    // Clock rate
    localparam int CLK_MHZ = 200;

    // Register indices, byte address four times the index; ADDR_DUTY is a byte address
    localparam logic [4:0] IDX_MODE  = 5'h1d;
    localparam logic [4:0] IDX_BEHAV = 5'h1e;
    localparam logic [4:0] IDX_PAGE  = 5'h1f;
    localparam logic [4:0] IDX_EXT_LO = 5'h10;
    localparam logic [7:0] ADDR_DUTY = 8'h80;

    // Field positions
    localparam int MODE_W         = 4;
    localparam int BEH_PULSE_BIT  = 12;
    localparam int BEH_RATE_LSB   = 10;
    localparam int BEH_STRETCH_LSB = 5;
    localparam int BEH_COMB_LSB   = 0;
    localparam logic [15:0] BEH_WMASK = 16'hddef;

    // Reset values
    localparam logic [3:0]  RST_MODE3 = 4'h8;
    localparam logic [3:0]  RST_MODE2 = 4'h0;
    localparam logic [3:0]  RST_MODE1 = 4'h2;
    localparam logic [3:0]  RST_MODE0 = 4'h1;
    localparam logic [1:0]  RST_RATE  = 2'h1;
    localparam logic [15:0] RST_PAGE  = 16'h0000;
    localparam logic [7:0]  RST_DUTY  = 8'h80;

    // Page select codes
    localparam logic [15:0] PAGE_MAIN = 16'h0000;
    localparam logic [15:0] PAGE_GPIO = 16'h0010;

    // Timing: base tick is half the shortest blink period
    localparam int BASE_TICK_US = 25000;
    localparam int PWM_FREQ_HZ  = 5000;
    localparam int PWM_STEPS    = 256;
    localparam int TICK_CYC     = BASE_TICK_US * CLK_MHZ;
    localparam int PWM_CYC      = (CLK_MHZ * 1000000) / PWM_FREQ_HZ;
    localparam logic [4:0] STRETCH_TICKS_MAX = 5'h10;

    // Per-output configuration
    typedef struct packed {
        logic [3:0] mode;
        logic       stretchSel;
        logic       combineDis;
    } lps_indicator_cfg_s;

    // Address space reached by an access
    typedef enum logic [1:0] {
        PS_MAIN = 2'b00,
        PS_EXT  = 2'b01,
        PS_GPIO = 2'b10
    } lps_space_e;
endpackage

// ---- rtl/lps_indicator.sv ----
// One indicator output: combine, blink or pulse-stretch, then optional pulsing
// Assumes shared tick, blink phase and pulse timing from the parent block
`timescale 1ns/1ps
module lps_indicator
    import lps_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire lps_indicator_cfg_s cfg,
    input  wire logic               tick,
    input  wire logic [1:0]         rate,
    input  wire logic               blinkPhase,
    input  wire logic               pulseEn,
    input  wire logic               pwmHigh,
    input  wire logic               statusLvl,
    input  wire logic               eventPulse,
    output logic                    indicatorOut
);
    logic [4:0] stretchCnt_ff;
    logic [4:0] nxt_stretchCnt;
    logic       out_ff;
    logic       nxt_out;
    logic       recent;
    logic       shaped;
    logic       active;

    // Hold recent activity for the stretch length chosen by the rate
    always_comb begin
        nxt_stretchCnt = stretchCnt_ff;
        if (eventPulse) begin
            nxt_stretchCnt = STRETCH_TICKS_MAX >> rate;
        end else if (tick && stretchCnt_ff != 5'h00) begin
            nxt_stretchCnt = stretchCnt_ff - 5'h01;
        end
    end

    // Combine, shape and pulse the output level
    always_comb begin
        recent = (stretchCnt_ff != 5'h00) | eventPulse;
        shaped = cfg.stretchSel ? recent : (recent & blinkPhase);
        if (cfg.combineDis) begin
            active = statusLvl;
        end else begin
            active = statusLvl & ~shaped;
        end
        nxt_out = pulseEn ? (active & pwmHigh) : active;
    end

    // Registered state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stretchCnt_ff <= 5'h00;
            out_ff        <= 1'b0;
        end else begin
            stretchCnt_ff <= nxt_stretchCnt;
            out_ff        <= nxt_out;
        end
    end

    assign indicatorOut = out_ff;
endmodule

// ---- rtl/lps_top.sv ----
// Indicator mode/behaviour registers, page select and indicator drive
// Assumes an APB master on clk; registers outside this block are reached elsewhere
//
// How it works
// - four 4-bit mode fields, one per output
// - mode fields reset to 8, 0, 2, 1
// - pulsing bit makes active outputs pulse 5 kHz
// - rate field selects blink and stretch timing
// - only first port rate field is used globally
// - per-output select picks stretch or blink
// - per-output bit disables link/activity combining
// - page register resets to zero, main space
// - writing zero returns addresses to main space
// - values one to four select extended spaces
// - value 0x10 sends addresses 0-30 to GPIO
// - extended pages leave addresses 0-15 untouched
`timescale 1ns/1ps
module lps_top
    import lps_pkg::*;
#(
    parameter int          PORT_ID   = 0,
    parameter int          TICK_CYCS = TICK_CYC,
    parameter int          PWM_CYCS  = PWM_CYC
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        softRst,
    input  wire logic [1:0]  globalRate,
    output logic [1:0]       rateOut,
    input  wire logic [3:0]  statusLvl,
    input  wire logic [3:0]  eventPulse,
    output logic [3:0]       indicatorOut,
    output logic [15:0]      indicatorMode,
    output lps_space_e       routeSpace,
    output logic             farHit
);
    localparam int          PWM_STEP_CYCS = (PWM_CYCS / PWM_STEPS > 0) ? PWM_CYCS / PWM_STEPS : 1;
    localparam logic [31:0] TICK_LAST     = 32'(TICK_CYCS - 1);
    localparam logic [31:0] PWM_STEP_LAST = 32'(PWM_STEP_CYCS - 1);

    logic [15:0] modeReg_ff;
    logic [15:0] nxt_modeReg;
    logic [15:0] behReg_ff;
    logic [15:0] nxt_behReg;
    logic [15:0] pageReg_ff;
    logic [15:0] nxt_pageReg;
    logic [7:0]  dutyReg_ff;
    logic [7:0]  nxt_dutyReg;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [31:0] tickPre_ff;
    logic [31:0] nxt_tickPre;
    logic [3:0]  blinkCnt_ff;
    logic [3:0]  nxt_blinkCnt;
    logic [31:0] pwmPre_ff;
    logic [31:0] nxt_pwmPre;
    logic [7:0]  pwmPhase_ff;
    logic [7:0]  nxt_pwmPhase;

    logic [4:0]  regIdx;
    logic        inWindow;
    logic        isDuty;
    logic        mapped;
    logic        localMode;
    logic        localBeh;
    logic        localPage;
    logic        wrStrobe;
    logic        tick;
    logic        blinkPhase;
    logic        pwmHigh;
    logic [1:0]  effRate;
    lps_space_e  space;
    logic [31:0] rdValue;

    // Address decode and page routing
    always_comb begin
        regIdx   = paddr[6:2];
        inWindow = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00);
        isDuty   = (paddr == ADDR_DUTY);
        mapped   = inWindow | isDuty;
        if (pageReg_ff == PAGE_MAIN) begin
            space = PS_MAIN;
        end else if (pageReg_ff == PAGE_GPIO) begin
            space = PS_GPIO;
        end else begin
            space = PS_EXT;
        end
        localPage = inWindow && (regIdx == IDX_PAGE);
        localMode = 1'b0;
        localBeh  = 1'b0;
        farHit    = 1'b0;
        if (!inWindow || localPage) begin
            farHit = 1'b0;
        end else if (space == PS_GPIO) begin
            farHit = 1'b1;
        end else if (space == PS_EXT && regIdx >= IDX_EXT_LO) begin
            farHit = 1'b1;
        end else if (space == PS_MAIN && regIdx == IDX_MODE) begin
            localMode = 1'b1;
        end else if (space == PS_MAIN && regIdx == IDX_BEHAV) begin
            localBeh = 1'b1;
        end else begin
            farHit = 1'b1;
        end
        farHit = farHit & psel;
    end

    assign routeSpace = space;
    assign wrStrobe   = psel & penable & pwrite & mapped;

    // Register writes; soft reset clears only the non-sticky page register
    always_comb begin
        nxt_modeReg = modeReg_ff;
        nxt_behReg  = behReg_ff;
        nxt_pageReg = pageReg_ff;
        nxt_dutyReg = dutyReg_ff;
        if (softRst) begin
            nxt_pageReg = RST_PAGE;
        end
        if (wrStrobe && localMode) begin
            nxt_modeReg = pwdata[15:0];
        end
        if (wrStrobe && localBeh) begin
            nxt_behReg = pwdata[15:0] & BEH_WMASK;
        end
        if (wrStrobe && localPage) begin
            nxt_pageReg = pwdata[15:0];
        end
        if (wrStrobe && isDuty) begin
            nxt_dutyReg = pwdata[7:0];
        end
    end

    // Register file, sticky fields reset only by hardware reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            modeReg_ff <= {RST_MODE3, RST_MODE2, RST_MODE1, RST_MODE0};
            behReg_ff  <= 16'(RST_RATE) << BEH_RATE_LSB;
            pageReg_ff <= RST_PAGE;
            dutyReg_ff <= RST_DUTY;
        end else begin
            modeReg_ff <= nxt_modeReg;
            behReg_ff  <= nxt_behReg;
            pageReg_ff <= nxt_pageReg;
            dutyReg_ff <= nxt_dutyReg;
        end
    end

    // Read data captured in the setup phase
    always_comb begin
        rdValue = 32'h0000_0000;
        if (localMode) begin
            rdValue = {16'h0000, modeReg_ff};
        end else if (localBeh) begin
            rdValue = {16'h0000, behReg_ff};
        end else if (localPage) begin
            rdValue = {16'h0000, pageReg_ff};
        end else if (isDuty) begin
            rdValue = {24'h00_0000, dutyReg_ff};
        end
        nxt_prdata = prdata_ff;
        if (psel && !penable) begin
            nxt_prdata = rdValue;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Zero-wait answer; unmapped addresses flag an error
    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Effective rate: the first port's field governs all ports
    assign rateOut = behReg_ff[BEH_RATE_LSB +: 2];
    assign effRate = (PORT_ID == 0) ? rateOut : globalRate;

    // Base tick and blink phase counter
    always_comb begin
        nxt_tickPre  = tickPre_ff + 32'h1;
        nxt_blinkCnt = blinkCnt_ff;
        tick         = (tickPre_ff == TICK_LAST);
        if (tick) begin
            nxt_tickPre  = 32'h0;
            nxt_blinkCnt = blinkCnt_ff + 4'h1;
        end
        blinkPhase = blinkCnt_ff[3 - effRate];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tickPre_ff  <= 32'h0;
            blinkCnt_ff <= 4'h0;
        end else begin
            tickPre_ff  <= nxt_tickPre;
            blinkCnt_ff <= nxt_blinkCnt;
        end
    end

    // Pulse-width timing for the pulsing mode
    always_comb begin
        nxt_pwmPre   = pwmPre_ff + 32'h1;
        nxt_pwmPhase = pwmPhase_ff;
        if (pwmPre_ff == PWM_STEP_LAST) begin
            nxt_pwmPre   = 32'h0;
            nxt_pwmPhase = pwmPhase_ff + 8'h01;
        end
        pwmHigh = (pwmPhase_ff < dutyReg_ff);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwmPre_ff   <= 32'h0;
            pwmPhase_ff <= 8'h00;
        end else begin
            pwmPre_ff   <= nxt_pwmPre;
            pwmPhase_ff <= nxt_pwmPhase;
        end
    end

    assign indicatorMode = modeReg_ff;

    // One shaping stage per indicator output
    for (genvar i = 0; i < 4; i++) begin : g_ind
        lps_indicator u_ind (
            .clk          (clk),
            .sys_rst      (sys_rst),
            .cfg          ({modeReg_ff[i*MODE_W +: MODE_W],
                            behReg_ff[BEH_STRETCH_LSB + i],
                            behReg_ff[BEH_COMB_LSB + i]}),
            .tick         (tick),
            .rate         (effRate),
            .blinkPhase   (blinkPhase),
            .pulseEn      (behReg_ff[BEH_PULSE_BIT]),
            .pwmHigh      (pwmHigh),
            .statusLvl    (statusLvl[i]),
            .eventPulse   (eventPulse[i]),
            .indicatorOut (indicatorOut[i])
        );
    end
endmodule

// ---- tb/lps_top_props.sv ----
// Concurrent checks on the lps_top ports
// Assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module lps_top_props
    import lps_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        softRst,
    input wire logic [1:0]  rateOut,
    input wire logic [15:0] indicatorMode,
    input wire lps_space_e  routeSpace,
    input wire logic        farHit
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Write strobe and low data half
    logic        wr;
    logic [15:0] wdLo;
    logic [1:0]  rateW;
    assign wr    = psel & penable & pwrite;
    assign wdLo  = pwdata[15:0];
    assign rateW = pwdata[11:10];
    mode_reset_a: assert property ($fell(sys_rst) |-> indicatorMode == 16'h8021)
        else $error("mode reset value wrong");
    mode_write_a: assert property (wr && paddr == 8'h74 && routeSpace == PS_MAIN
        |=> indicatorMode == $past(wdLo)) else $error("mode write lost");
    mode_hold_a: assert property (!(wr && paddr == 8'h74) |=> $stable(indicatorMode))
        else $error("mode changed without write");
    rate_write_a: assert property (wr && paddr == 8'h78 && routeSpace == PS_MAIN
        |=> rateOut == $past(rateW)) else $error("rate write lost");
    page_main_a: assert property (wr && paddr == 8'h7c && wdLo == 16'h0 |=> routeSpace == PS_MAIN)
        else $error("page zero not main");
    page_gpio_a: assert property (wr && paddr == 8'h7c && wdLo == 16'h0010 && !softRst
        |=> routeSpace == PS_GPIO) else $error("gpio page not decoded");
    page_ext_a: assert property (wr && paddr == 8'h7c && wdLo inside {[16'h1:16'h4]} && !softRst
        |=> routeSpace == PS_EXT) else $error("extended page not decoded");
    soft_clear_a: assert property (softRst && !wr |=> routeSpace == PS_MAIN)
        else $error("soft reset kept page");
    ext_low_a: assert property (psel && routeSpace == PS_EXT && paddr < 8'h40 && paddr[1:0] == 2'h0
        |-> farHit) else $error("low register not passed on");
    ext_high_a: assert property (psel && routeSpace == PS_EXT && paddr inside {[8'h40:8'h78]}
        && paddr[1:0] == 2'h0 |-> farHit) else $error("high register not redirected");
    gpio_far_a: assert property (psel && routeSpace == PS_GPIO && paddr < 8'h7c
        && paddr[1:0] == 2'h0 |-> farHit) else $error("gpio access stayed local");
    page_local_a: assert property (psel && paddr == 8'h7c |-> !farHit)
        else $error("page register redirected");
    bad_addr_a: assert property (psel && penable && paddr == 8'h84 |-> pslverr)
        else $error("unmapped access accepted");
endmodule
bind lps_top lps_top_props u_lps_top_props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .softRst(softRst), .rateOut(rateOut), .indicatorMode(indicatorMode),
    .routeSpace(routeSpace), .farHit(farHit));

// ---- tb/lps_led_board.sv ----
// Board indicator model: counts lit cycles of each output
// Assumes active-high drive sampled on clk
`timescale 1ns/1ps
module lps_led_board (
    input  wire logic             clk,
    input  wire logic             clr,
    input  wire logic [3:0]       ledDrive,
    output logic      [3:0][15:0] litCount
);
    // Lit-cycle counters, cleared while clr is high
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            litCount[i] <= clr ? 16'h0 : litCount[i] + 16'(ledDrive[i]);
        end
    end
endmodule

// ---- tb/tb_lps_top.sv ----
// Testbench for lps_top: APB register, page and indicator checks
// Assumes short tick and PWM parameters for simulation
`timescale 1ns/1ps
module tb_lps_top
    import lps_pkg::*;
;
    logic             clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic             softRst = 1'b0;
    logic             ledClr = 1'b1;
    logic [7:0]       paddr = 8'h0;
    logic [31:0]      pwdata = 32'h0;
    logic [3:0]       statusLvl = 4'h0;
    logic [3:0]       eventPulse = 4'h0;
    logic [31:0]      prdata, rd, w32, b32;
    logic             pready, pslverr, farHit, sawErr;
    logic [3:0]       indicatorOut;
    logic [1:0]       rateOut;
    logic [15:0]      indicatorMode, m;
    lps_space_e       routeSpace;
    logic [3:0][15:0] litCount;
    logic [15:0]      pages [8] = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h7, 16'h10, 16'h1, 16'h0};
    logic [7:0]       duties [3] = '{8'h80, 8'h40, 8'h00};
    logic [15:0]      behs [4] = '{16'h01e0, 16'h0de0, 16'h01ef, 16'h0000};
    int               fail_count = 0;
    int               checked = 0;
    // Clock
    always #2.5 clk = ~clk;
    lps_top #(.PORT_ID(0), .TICK_CYCS(4), .PWM_CYCS(512)) u_lps_top (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .softRst(softRst),
        .globalRate(2'h0), .rateOut(rateOut), .statusLvl(statusLvl), .eventPulse(eventPulse),
        .indicatorOut(indicatorOut), .indicatorMode(indicatorMode), .routeSpace(routeSpace),
        .farHit(farHit));
    lps_led_board u_lps_led_board (.clk(clk), .clr(ledClr), .ledDrive(indicatorOut),
        .litCount(litCount));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        sawErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected page decode
    function automatic logic [1:0] spaceExp(input logic [15:0] p);
        return (p == 16'h0) ? 2'b00 : (p == 16'h10) ? 2'b10 : 2'b01;
    endfunction
    // Dark cycles one event may cause on a lit output; four-cycle tick, blink only at the slowest rate
    function automatic logic darkOk(input logic [15:0] beh, input int dark);
        int span;
        span = 4 * (16 >> beh[11:10]);
        if (beh[0])
            return dark == 0;
        else if (beh[5])
            return dark >= span - 2 && dark <= span + 1;
        else
            return dark >= span / 2 - 3 && dark <= span / 2 + 2;
    endfunction
    task automatic stop_test();
        $display("mismatches %0d checks %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'hf8d3));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, 8'h74, 32'h0); check(rd, 32'h8021);
        apb(1'b0, 8'h78, 32'h0); check(rd, 32'h0400);
        apb(1'b0, 8'h7c, 32'h0); check(rd, 32'h0);
        repeat (8) begin
            w32 = $urandom;
            b32 = $urandom;
            m = w32[15:0];
            apb(1'b1, 8'h74, w32);
            apb(1'b1, 8'h78, b32);
            apb(1'b0, 8'h74, 32'h0); check(rd, {16'h0, m});
            apb(1'b0, 8'h78, 32'h0); check(rd, {16'h0, b32[15:0] & 16'hddef});
            check(rateOut, b32[11:10]);
        end
        foreach (pages[i]) begin
            apb(1'b1, 8'h7c, {16'hffff, pages[i]});
            apb(1'b0, 8'h7c, 32'h0); check(rd, {16'h0, pages[i]});
            check(routeSpace, spaceExp(pages[i]));
            apb(1'b0, 8'h08, 32'h0);
            apb(1'b0, 8'h74, 32'h0); check(rd, (pages[i] == 16'h0) ? {16'h0, m} : 32'h0);
        end
        apb(1'b1, 8'h84, 32'hffff); check(sawErr, 1'b1);
        apb(1'b0, 8'h80, 32'h0); check(rd, 32'h80);
        apb(1'b1, 8'h7c, 32'h1);
        @(posedge clk);
        softRst <= 1'b1;
        @(posedge clk);
        softRst <= 1'b0;
        apb(1'b0, 8'h74, 32'h0); check(rd, {16'h0, m});
        check(routeSpace, PS_MAIN);
        apb(1'b1, 8'h78, 32'h000f);
        repeat (6) begin
            statusLvl <= 4'($urandom);
            repeat (3) @(posedge clk);
            check(indicatorOut, statusLvl);
        end
        statusLvl <= 4'hf;
        apb(1'b1, 8'h78, 32'h100f);
        foreach (duties[i]) begin
            apb(1'b1, 8'h80, {24'h0, duties[i]});
            repeat (4) @(posedge clk);
            ledClr <= 1'b0;
            repeat (512) @(posedge clk);
            ledClr <= 1'b1;
            @(posedge clk);
            check(litCount[0], {duties[i], 1'b0});
            check(litCount[3], {duties[i], 1'b0});
        end
        // One event on a lit output: stretch, fast stretch, combine off, blink
        foreach (behs[i]) begin
            apb(1'b1, 8'h78, {16'h0, behs[i]});
            repeat (2) @(posedge clk);
            ledClr <= 1'b0;
            eventPulse <= 4'h1;
            @(posedge clk);
            eventPulse <= 4'h0;
            repeat (99) @(posedge clk);
            ledClr <= 1'b1;
            @(posedge clk);
            check(darkOk(behs[i], 100 - litCount[0]), 1'b1);
            check(litCount[1], 16'd100);
        end
        stop_test();
    end
    // Watchdog
    initial begin
        #100us;
        fail_count++;
        stop_test();
    end
endmodule
